// File: logic/board_io_port_bits.sv
// Board I/O ports: floppy control, system straps and bank, counters, printer
`timescale 1ns/100ps
`default_nettype none

module board_io_port_bits #(
  parameter int CTR_WIDTH = 8
) (
  input  wire logic       clk,
  input  wire logic       reset,
  // Host I/O port access
  input  wire logic [7:0] ioAddr,
  input  wire logic       ioWrStb,
  input  wire logic       ioRdStb,
  input  wire logic [7:0] ioWrData,
  output logic      [7:0] ioRdData,
  output logic            ioRdValid,
  // Floppy control port
  output logic            sideSelect,
  input  wire logic       fdcIrq,
  output logic      [3:0] driveSelect,
  input  wire logic       headLoaded,
  output logic            densitySelectN,
  // System port
  input  wire logic       driveTypeStrap,
  input  wire logic       boardTypeStrap,
  output logic            bankSelHi,
  output logic            bankSelLo,
  input  wire logic       diskChangeN,
  output logic            controllerResetN,
  input  wire logic       coprocPinIn,
  output logic            coprocPinOut,
  output logic            coprocPinOe,
  // Counter channels
  input  wire logic       clk2MHz,
  input  wire logic       indexPulse,
  output logic            baudClkA,
  output logic            baudClkB,
  // Printer
  input  wire logic       printerUnnamed,
  input  wire logic       printerSelect,
  input  wire logic       printerBusy,
  input  wire logic       printerOutOfPaper,
  input  wire logic       printerFault,
  output logic            printerInputPrime,
  output logic            printerStrobe,
  output logic      [7:0] printerData
);

  function automatic logic portHit(input logic [7:0] addr, input logic [7:0] offset);
    portHit = (addr == offset);
  endfunction : portHit

  logic       wrFloppy;
  logic       wrSys;
  logic       wrPrnStatus;
  logic       wrPrnData;
  logic [7:0] floppyLatch;
  logic [7:0] sysLatch;
  logic [7:0] prnStatusLatch;
  logic [7:0] prnDataLatch;
  logic [7:0] floppyRead;
  logic [7:0] sysRead;
  logic [7:0] prnStatusRead;
  logic [7:0] prnDataRead;
  logic [7:0] floppyPins;
  logic [7:0] sysPins;
  logic [7:0] prnStatusPins;
  logic [7:0] sysOutMask;

  localparam int CTR_CHANNELS_W = board_io_pkg::CTR_CHANNELS;
  logic [CTR_CHANNELS_W-1:0] ctrUnused;
  logic [CTR_WIDTH-1:0] ctrCount [CTR_CHANNELS_W];
  logic                 ctrOut   [CTR_CHANNELS_W];
  logic                 ctrLoad  [CTR_CHANNELS_W];

  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic       rdValid_q;
  logic       rdValid_d;
  logic       boardLater_q;
  logic       boardLater_d;

  assign wrFloppy    = ioWrStb & portHit(ioAddr, board_io_pkg::FLOPPY_CTL_OFFSET);
  assign wrSys       = ioWrStb & portHit(ioAddr, board_io_pkg::SYS_PORT_OFFSET);
  assign wrPrnStatus = ioWrStb & portHit(ioAddr, board_io_pkg::PRN_STATUS_OFFSET);
  assign wrPrnData   = ioWrStb & portHit(ioAddr, board_io_pkg::PRN_DATA_OFFSET);

  // Input bit positions of the floppy port
  always_comb
  begin
    floppyPins                             = 8'h00;
    floppyPins[board_io_pkg::FLP_IRQ_BIT]  = fdcIrq;
    floppyPins[board_io_pkg::FLP_HEAD_BIT] = headLoaded;
  end

  // Input bit positions of the system port
  always_comb
  begin
    sysPins                                = 8'h00;
    sysPins[board_io_pkg::SYS_DRVTYPE_BIT] = driveTypeStrap;
    sysPins[board_io_pkg::SYS_BOARD_BIT]   = boardTypeStrap;
    sysPins[board_io_pkg::SYS_DSKCHG_BIT]  = diskChangeN;
    sysPins[board_io_pkg::SYS_COPROC_BIT]  = coprocPinIn;
  end

  // Bit 0 is an output only on the earlier board
  always_comb
  begin
    sysOutMask                               = board_io_pkg::SYS_OUT_MASK;
    sysOutMask[board_io_pkg::SYS_COPROC_BIT] = ~boardLater_q;
  end

  always_comb
  begin
    prnStatusPins                                = 8'h00;
    prnStatusPins[board_io_pkg::PRN_UNNAMED_BIT] = printerUnnamed;
    prnStatusPins[board_io_pkg::PRN_SELECT_BIT]  = printerSelect;
    prnStatusPins[board_io_pkg::PRN_BUSY_BIT]    = printerBusy;
    prnStatusPins[board_io_pkg::PRN_PAPER_BIT]   = printerOutOfPaper;
    prnStatusPins[board_io_pkg::PRN_FAULT_BIT]   = printerFault;
  end

  io_port_reg #(
    .RESET_VALUE (board_io_pkg::FLP_RESET_VALUE)
  ) floppyPort (
    .clk     (clk),
    .reset   (reset),
    .wrEn    (wrFloppy),
    .wrData  (ioWrData),
    .outMask (board_io_pkg::FLP_OUT_MASK),
    .pinIn   (floppyPins),
    .latched (floppyLatch),
    .rdValue (floppyRead)
  );

  io_port_reg #(
    .RESET_VALUE (board_io_pkg::SYS_RESET_VALUE)
  ) sysPort (
    .clk     (clk),
    .reset   (reset),
    .wrEn    (wrSys),
    .wrData  (ioWrData),
    .outMask (sysOutMask),
    .pinIn   (sysPins),
    .latched (sysLatch),
    .rdValue (sysRead)
  );

  io_port_reg #(
    .RESET_VALUE (board_io_pkg::PRN_RESET_VALUE)
  ) prnStatusPort (
    .clk     (clk),
    .reset   (reset),
    .wrEn    (wrPrnStatus),
    .wrData  (ioWrData),
    .outMask (board_io_pkg::PRN_OUT_MASK),
    .pinIn   (prnStatusPins),
    .latched (prnStatusLatch),
    .rdValue (prnStatusRead)
  );

  io_port_reg #(
    .RESET_VALUE (board_io_pkg::DATA_RESET_VALUE)
  ) prnDataPort (
    .clk     (clk),
    .reset   (reset),
    .wrEn    (wrPrnData),
    .wrData  (ioWrData),
    .outMask (board_io_pkg::DATA_OUT_MASK),
    .pinIn   (8'h00),
    .latched (prnDataLatch),
    .rdValue (prnDataRead)
  );

  // Channels 0 to 2 divide the 2 MHz input, channel 3 counts index pulses
  genvar ch;
  generate
    for (ch = 0; ch < CTR_CHANNELS_W; ch++)
    begin : gCtr
      assign ctrLoad[ch] = ioWrStb & portHit(ioAddr, board_io_pkg::CTR_BASE_OFFSET + 8'(ch));
      counter_chan #(
        .WIDTH (CTR_WIDTH)
      ) chan (
        .clk       (clk),
        .reset     (reset),
        .trigIn    ((ch == board_io_pkg::CTR_INDEX_CHAN) ? indexPulse : clk2MHz),
        .loadEn    (ctrLoad[ch]),
        .loadValue (ioWrData[CTR_WIDTH-1:0]),
        .count     (ctrCount[ch]),
        .outLevel  (ctrOut[ch])
      );
      assign ctrUnused[ch] = ctrOut[ch];
    end
  endgenerate

  // Read strobe returns one cycle later from a register
  always_comb
  begin
    rdData_d  = rdData_q;
    rdValid_d = ioRdStb;
    if (ioRdStb)
    begin
      rdData_d = 8'h00;
      if (portHit(ioAddr, board_io_pkg::FLOPPY_CTL_OFFSET))
      begin
        rdData_d = floppyRead;
      end
      else if (portHit(ioAddr, board_io_pkg::SYS_PORT_OFFSET))
      begin
        rdData_d = sysRead;
      end
      else if (portHit(ioAddr, board_io_pkg::PRN_STATUS_OFFSET))
      begin
        rdData_d = prnStatusRead;
      end
      else if (portHit(ioAddr, board_io_pkg::PRN_DATA_OFFSET))
      begin
        rdData_d = prnDataRead;
      end
      else
      begin
        for (int i = 0; i < CTR_CHANNELS_W; i++)
        begin
          if (portHit(ioAddr, board_io_pkg::CTR_BASE_OFFSET + 8'(i)))
          begin
            rdData_d = 8'(ctrCount[i]);
          end
        end
      end
    end
  end

  // Strap sampled every cycle; a live strap change just redirects bit 0
  always_comb
  begin
    boardLater_d = boardTypeStrap;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdData_q     <= 8'h00;
      rdValid_q    <= 1'b0;
      boardLater_q <= 1'b0;
    end
    else
    begin
      rdData_q     <= rdData_d;
      rdValid_q    <= rdValid_d;
      boardLater_q <= boardLater_d;
    end
  end

  assign ioRdData  = rdData_q;
  assign ioRdValid = rdValid_q;

  assign sideSelect     = floppyLatch[board_io_pkg::FLP_SIDE_BIT];
  // Bit 2 is drive A, up to bit 5 for drive D
  assign driveSelect    = floppyLatch[board_io_pkg::FLP_DRVD_BIT:board_io_pkg::FLP_DRVA_BIT];
  assign densitySelectN = floppyLatch[board_io_pkg::FLP_DENS_BIT];

  assign bankSelHi        = sysLatch[board_io_pkg::SYS_BANK_HI_BIT];
  assign bankSelLo        = sysLatch[board_io_pkg::SYS_BANK_LO_BIT];
  // Pulse width of the controller reset is timed by software
  assign controllerResetN = sysLatch[board_io_pkg::SYS_CTLRST_BIT];
  assign coprocPinOut     = sysLatch[board_io_pkg::SYS_COPROC_BIT];
  assign coprocPinOe      = ~boardLater_q;

  assign baudClkA = ctrOut[0];
  assign baudClkB = ctrOut[2];

  assign printerInputPrime = prnStatusLatch[board_io_pkg::PRN_PRIME_BIT];
  assign printerStrobe     = prnStatusLatch[board_io_pkg::PRN_STROBE_BIT];
  assign printerData       = prnDataLatch;

endmodule : board_io_port_bits

`default_nettype wire

// File: pkg/board_io_pkg.sv
// Package: port offsets, bit positions, masks and reset values of the board I/O ports
`default_nettype none

package board_io_pkg;

  localparam logic [7:0] FLOPPY_CTL_OFFSET = 8'h08;
  localparam logic [7:0] SYS_PORT_OFFSET   = 8'h09;
  localparam logic [7:0] CTR_BASE_OFFSET   = 8'h0c;
  localparam logic [7:0] PRN_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] PRN_DATA_OFFSET   = 8'h11;
  localparam int         CTR_CHANNELS      = 4;
  localparam int         CTR_INDEX_CHAN    = 3;

  localparam int FLP_SIDE_BIT  = 7;
  localparam int FLP_IRQ_BIT   = 6;
  localparam int FLP_DRVD_BIT  = 5;
  localparam int FLP_DRVA_BIT  = 2;
  localparam int FLP_HEAD_BIT  = 1;
  localparam int FLP_DENS_BIT  = 0;

  localparam int SYS_DRVTYPE_BIT = 7;
  localparam int SYS_BOARD_BIT   = 6;
  localparam int SYS_BANK_HI_BIT = 4;
  localparam int SYS_BANK_LO_BIT = 3;
  localparam int SYS_DSKCHG_BIT  = 2;
  localparam int SYS_CTLRST_BIT  = 1;
  localparam int SYS_COPROC_BIT  = 0;

  localparam int PRN_UNNAMED_BIT = 7;
  localparam int PRN_SELECT_BIT  = 6;
  localparam int PRN_BUSY_BIT    = 5;
  localparam int PRN_PAPER_BIT   = 4;
  localparam int PRN_FAULT_BIT   = 3;
  localparam int PRN_PRIME_BIT   = 1;
  localparam int PRN_STROBE_BIT  = 0;

  localparam logic [7:0] FLP_OUT_MASK = 8'hbd;
  localparam logic [7:0] SYS_OUT_MASK = 8'h1a;
  localparam logic [7:0] PRN_OUT_MASK = 8'h03;
  localparam logic [7:0] DATA_OUT_MASK = 8'hff;

  localparam logic [7:0] FLP_RESET_VALUE = 8'h00;
  localparam logic [7:0] SYS_RESET_VALUE = 8'h02;
  localparam logic [7:0] PRN_RESET_VALUE = 8'h00;
  localparam logic [7:0] DATA_RESET_VALUE = 8'h00;
  localparam logic [7:0] CTR_RESET_VALUE = 8'h00;

endpackage : board_io_pkg

`default_nettype wire

// File: logic/io_port_reg.sv
// One parallel port byte: output latch plus live pin readback
`timescale 1ns/100ps
`default_nettype none

module io_port_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  input  wire logic [7:0] outMask,
  input  wire logic [7:0] pinIn,
  output logic      [7:0] latched,
  output logic      [7:0] rdValue
);

  logic [7:0] latched_q;
  logic [7:0] latched_d;

  always_comb
  begin
    latched_d = latched_q;
    if (wrEn)
    begin
      latched_d = wrData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      latched_q <= RESET_VALUE;
    end
    else
    begin
      latched_q <= latched_d;
    end
  end

  assign latched = latched_q;
  // Output bits echo the latch, input bits the pins at read time
  assign rdValue = (latched_q & outMask) | (pinIn & ~outMask);

endmodule : io_port_reg

`default_nettype wire

// File: logic/counter_chan.sv
// Down counter channel: counts rising edges of its trigger, toggles output on terminal count
`timescale 1ns/100ps
`default_nettype none

module counter_chan #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             trigIn,
  input  wire logic             loadEn,
  input  wire logic [WIDTH-1:0] loadValue,
  output logic      [WIDTH-1:0] count,
  output logic                  outLevel
);

  logic             trigPrev_q;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] constant_q;
  logic [WIDTH-1:0] constant_d;
  logic             out_q;
  logic             out_d;
  logic             trigEdge;

  assign trigEdge = trigIn & ~trigPrev_q;

  always_comb
  begin
    count_d    = count_q;
    constant_d = constant_q;
    out_d      = out_q;
    if (loadEn)
    begin
      constant_d = loadValue;
      count_d    = loadValue;
    end
    else if (trigEdge)
    begin
      // Constant of zero wraps and so divides by the full range
      if (count_q == WIDTH'(1))
      begin
        count_d = constant_q;
        out_d   = ~out_q;
      end
      else
      begin
        count_d = count_q - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      trigPrev_q <= 1'b0;
      count_q    <= '0;
      constant_q <= '0;
      out_q      <= 1'b0;
    end
    else
    begin
      trigPrev_q <= trigIn;
      count_q    <= count_d;
      constant_q <= constant_d;
      out_q      <= out_d;
    end
  end

  assign count    = count_q;
  assign outLevel = out_q;

endmodule : counter_chan

`default_nettype wire

// File: tb/board_io_port_bits_sva.sv
// Checker: port-level properties of the board I/O ports
`timescale 1ns/100ps
`default_nettype none

module board_io_port_bits_sva (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] ioAddr,
  input wire logic       ioWrStb,
  input wire logic       ioRdStb,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic       ioRdValid,
  input wire logic       sideSelect,
  input wire logic       fdcIrq,
  input wire logic [3:0] driveSelect,
  input wire logic       headLoaded,
  input wire logic       densitySelectN,
  input wire logic       bankSelHi,
  input wire logic       bankSelLo,
  input wire logic [7:0] printerData
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic wrF;
  logic wrP;
  assign wrF = ioWrStb && ioAddr == 8'h08;
  assign wrP = ioWrStb && ioAddr == 8'h11;

  property p_side;
    wrF |=> sideSelect == $past(ioWrData[7]);
  endproperty
  a_side: assert property (p_side) else $error("side select not latched");
  property p_drv;
    wrF |=> driveSelect == $past(ioWrData[5:2]);
  endproperty
  a_drv: assert property (p_drv) else $error("drive select not latched");
  property p_dens;
    wrF |=> densitySelectN == $past(ioWrData[0]);
  endproperty
  a_dens: assert property (p_dens) else $error("density select not latched");
  property p_bank;
    ioWrStb && ioAddr == 8'h09 |=> {bankSelHi, bankSelLo} == $past(ioWrData[4:3]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank number wrong");
  property p_prn;
    wrP |=> printerData == $past(ioWrData);
  endproperty
  a_prn: assert property (p_prn) else $error("printer data not latched");
  property p_hold;
    !wrP |=> $stable(printerData);
  endproperty
  a_hold: assert property (p_hold) else $error("printer data moved without write");
  property p_rdf;
    ioRdStb && ioAddr == 8'h08 |=> ioRdValid && ioRdData[6] == $past(fdcIrq) && ioRdData[1] == $past(headLoaded);
  endproperty
  a_rdf: assert property (p_rdf) else $error("floppy input bits wrong");
  property p_valid;
    !ioRdStb |=> !ioRdValid;
  endproperty
  a_valid: assert property (p_valid) else $error("read valid without read");
endmodule : board_io_port_bits_sva

bind board_io_port_bits board_io_port_bits_sva u_board_io_port_bits_sva (.clk(clk), .reset(reset),
  .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData),
  .ioRdValid(ioRdValid), .sideSelect(sideSelect), .fdcIrq(fdcIrq), .driveSelect(driveSelect),
  .headLoaded(headLoaded), .densitySelectN(densitySelectN), .bankSelHi(bankSelHi),
  .bankSelLo(bankSelLo), .printerData(printerData));

`default_nettype wire

// File: tb/board_io_partner.sv
// Far-side model: floppy controller, printer and coprocessor pins
`timescale 1ns/100ps
`default_nettype none

module board_io_partner (
  input  wire logic       clk,
  input  wire logic       controllerResetN,
  input  wire logic [3:0] driveSelect,
  input  wire logic       printerStrobe,
  input  wire logic       coprocPinOut,
  input  wire logic       coprocPinOe,
  input  wire logic [3:0] pinRand,
  output logic            fdcIrq,
  output logic            headLoaded,
  output logic            diskChangeN,
  output logic            printerBusy,
  output logic            printerFault,
  output logic            coprocPinIn
);
  logic [2:0] busyCnt = 3'h0;
  logic       strobeQ = 1'b0;
  logic       doneQ = 1'b0;
  initial {fdcIrq, headLoaded, diskChangeN, printerFault} = 4'h0;
  always @(posedge clk)
  begin
    fdcIrq <= controllerResetN & pinRand[0];
    headLoaded <= (|driveSelect) & pinRand[1];
    diskChangeN <= pinRand[3];
    printerFault <= pinRand[2];
    strobeQ <= printerStrobe;
    busyCnt <= (printerStrobe & ~strobeQ) ? 3'h4 : busyCnt - {2'h0, |busyCnt};
    doneQ <= pinRand[0] ^ pinRand[1];
  end
  // Busy some cycles after a strobe, so reads catch both levels
  assign printerBusy = |busyCnt;
  assign coprocPinIn = (coprocPinOe === 1'b1) ? coprocPinOut : doneQ;
endmodule : board_io_partner

`default_nettype wire

// File: tb/board_io_port_bits_tb_top.sv
// Testbench: board I/O ports against the far-side model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module board_io_port_bits_tb_top;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] ioAddr = 8'h00;
  logic [7:0] ioWrData = 8'h00;
  logic       ioWrStb = 1'b0;
  logic       ioRdStb = 1'b0;
  logic       driveTypeStrap = 1'b0;
  logic       boardTypeStrap = 1'b1;
  logic       printerUnnamed = 1'b0;
  logic       printerSelect = 1'b0;
  logic       printerOutOfPaper = 1'b0;
  logic       clk2MHz = 1'b0;
  logic       indexPulse = 1'b0;
  logic [3:0] pinRand = 4'h0;
  logic [7:0] ioRdData, printerData;
  logic [3:0] driveSelect;
  logic       ioRdValid, sideSelect, densitySelectN, bankSelHi, bankSelLo, controllerResetN;
  logic       coprocPinOut, coprocPinOe, baudClkA, baudClkB, printerInputPrime, printerStrobe;
  logic       fdcIrq, headLoaded, diskChangeN, printerBusy, printerFault, coprocPinIn;
  logic [7:0] flp = 8'h00, sys = 8'h02, prn = 8'h00, dat = 8'h00;
  logic [7:0] ctrE [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] addrTab [5] = '{8'h08, 8'h09, 8'h10, 8'h11, 8'h20};
  logic [31:0] r;
  logic       aPrev, bPrev;
  int         aTog, bTog, cycles;
  int         fail_count = 0;
  int         tests_run = 0;
  integer     seed = 32'h7a7b3868;

  board_io_port_bits u_board_io_port_bits (.clk(clk), .reset(reset), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
    .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
    .sideSelect(sideSelect), .fdcIrq(fdcIrq), .driveSelect(driveSelect), .headLoaded(headLoaded),
    .densitySelectN(densitySelectN), .driveTypeStrap(driveTypeStrap), .boardTypeStrap(boardTypeStrap),
    .bankSelHi(bankSelHi), .bankSelLo(bankSelLo), .diskChangeN(diskChangeN),
    .controllerResetN(controllerResetN), .coprocPinIn(coprocPinIn), .coprocPinOut(coprocPinOut),
    .coprocPinOe(coprocPinOe), .clk2MHz(clk2MHz), .indexPulse(indexPulse), .baudClkA(baudClkA),
    .baudClkB(baudClkB), .printerUnnamed(printerUnnamed), .printerSelect(printerSelect),
    .printerBusy(printerBusy), .printerOutOfPaper(printerOutOfPaper), .printerFault(printerFault),
    .printerInputPrime(printerInputPrime), .printerStrobe(printerStrobe), .printerData(printerData));

  board_io_partner u_board_io_partner (.clk(clk), .controllerResetN(controllerResetN),
    .driveSelect(driveSelect), .printerStrobe(printerStrobe), .coprocPinOut(coprocPinOut),
    .coprocPinOe(coprocPinOe), .pinRand(pinRand), .fdcIrq(fdcIrq), .headLoaded(headLoaded),
    .diskChangeN(diskChangeN), .printerBusy(printerBusy), .printerFault(printerFault),
    .coprocPinIn(coprocPinIn));

  initial
  begin
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] expRd(input logic [7:0] a);
    case (a)
      8'h08: return (flp & board_io_pkg::FLP_OUT_MASK) | {1'b0, fdcIrq, 4'h0, headLoaded, 1'b0};
      8'h09: return {driveTypeStrap, boardTypeStrap, 1'b0, sys[4:3], diskChangeN, sys[1],
        boardTypeStrap ? coprocPinIn : sys[0]};
      8'h10: return {printerUnnamed, printerSelect, printerBusy, printerOutOfPaper, printerFault,
        1'b0, prn[1:0]};
      8'h11: return dat;
      8'h0c, 8'h0d, 8'h0e, 8'h0f: return ctrE[a[1:0]];
      default: return 8'h00;
    endcase
  endfunction : expRd

  function automatic logic [7:0] ctrExp(input int c, input int n);
    return (n % c == 0) ? 8'(c) : 8'(c - n % c);
  endfunction : ctrExp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    {ioAddr, ioWrData, ioWrStb} = {a, d, 1'b1};
    @(posedge clk);
    #1;
    ioWrStb = 1'b0;
    case (a)
      8'h08: flp = d;
      8'h09: sys = d;
      8'h10: prn = d;
      8'h11: dat = d;
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    @(posedge clk);
    #1;
    {ioAddr, ioRdStb} = {a, 1'b1};
    e = expRd(a);
    @(posedge clk);
    #1;
    ioRdStb = 1'b0;
    `CHK(ioRdValid, 1'b1)
    `CHK(ioRdData, e)
  endtask : rd

  task automatic edges(input logic idx, input int n);
    repeat (n)
    begin
      repeat (25) @(posedge clk);
      #1;
      {indexPulse, clk2MHz} = {idx, ~idx};
      repeat (25) @(posedge clk);
      #1;
      {indexPulse, clk2MHz} = 2'b00;
    end
  endtask : edges

  task automatic summarize();
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  always @(posedge clk)
  begin
    aTog += int'(baudClkA !== aPrev);
    bTog += int'(baudClkB !== bPrev);
    {aPrev, bPrev} = {baudClkA, baudClkB};
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 5; i++)
      rd(addrTab[i]);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h08, {i[0], 1'b0, 4'h1 << i, 1'b0, i[1]});
      `CHK({sideSelect, driveSelect, densitySelectN}, {i[0], 4'h1 << i, i[1]})
      wr(8'h09, {3'h0, i[1:0], 3'h2});
      `CHK({bankSelHi, bankSelLo, controllerResetN}, {i[1:0], 1'b1})
    end
    // Controller held in reset for 50 us, then released
    wr(8'h09, 8'h00);
    `CHK(controllerResetN, 1'b0)
    repeat (5000) @(posedge clk);
    wr(8'h09, 8'h02);
    `CHK(controllerResetN, 1'b1)
    for (int k = 0; k < 40; k++)
    begin
      r = $random(seed);
      {pinRand, driveTypeStrap, printerUnnamed, printerSelect, printerOutOfPaper} = r[23:16];
      if (r[3])
        wr(addrTab[r[2:0] % 5], r[15:8]);
      else
        rd(addrTab[r[2:0] % 5]);
    end
    boardTypeStrap = 1'b0;
    wr(8'h09, 8'h03);
    rd(8'h09);
    `CHK({coprocPinOe, coprocPinOut}, 2'b11)
    boardTypeStrap = 1'b1;
    wr(8'h0c, 8'h02);
    wr(8'h0d, 8'h04);
    wr(8'h0e, 8'h01);
    wr(8'h0f, 8'h03);
    aTog = 0;
    bTog = 0;
    edges(1'b0, 10);
    repeat (4) @(posedge clk);
    `CHK(aTog, 5)
    `CHK(bTog, 10)
    ctrE[1] = ctrExp(4, 10);
    rd(8'h0d);
    edges(1'b1, 1);
    ctrE[3] = ctrExp(3, 1);
    rd(8'h0f);
    edges(1'b1, 2);
    ctrE[3] = ctrExp(3, 3);
    rd(8'h0f);
    wr(8'h10, 8'h03);
    `CHK({printerInputPrime, printerStrobe}, 2'b11)
    wr(8'h11, 8'ha5);
    `CHK(printerData, 8'ha5)
    // Mid-run reset must bring the floppy, system and printer data latches and counter 3 back to their reset values
    @(posedge clk);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    {flp, sys, prn, dat, ctrE[3]} = {8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
    `CHK({sideSelect, driveSelect, densitySelectN, controllerResetN, printerData}, 15'h0100)
    rd(8'h09);
    rd(8'h0f);
    summarize();
  end
endmodule : board_io_port_bits_tb_top

`default_nettype wire
